// file: src/rgbp_panel_rx.sv
// receiving side of a 480x272 24-bit parallel rgb panel interface
`include "rgbp_params.svh"
module rgbp_panel_rx (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // panel pins
  input wire logic pixel_clock_i,
  input wire logic display_on_i,
  input wire logic hsync_n_i,
  input wire logic vsync_n_i,
  input wire logic pixel_valid_i,
  input wire logic [`RGBP_COLOR_W-1:0] red_bits_i,
  input wire logic [`RGBP_COLOR_W-1:0] green_bits_i,
  input wire logic [`RGBP_COLOR_W-1:0] blue_bits_i,
  // captured pixel stream
  output logic pix_stb_o,
  output logic [`RGBP_COLOR_W-1:0] pix_red_o,
  output logic [`RGBP_COLOR_W-1:0] pix_green_o,
  output logic [`RGBP_COLOR_W-1:0] pix_blue_o,
  output logic [`RGBP_CNT_W-1:0] pix_x_o,
  output logic [`RGBP_CNT_W-1:0] pix_y_o,
  output logic frame_start_o,
  // status
  output logic standby_o,
  output logic htiming_err_o,
  output logic vtiming_err_o
);
  localparam int CW = `RGBP_COLOR_W;
  localparam int NW = 3 * CW + 5;
  localparam logic [9:0] HA = 10'(`RGBP_H_ACTIVE);
  localparam logic [9:0] VA = 10'(`RGBP_V_ACTIVE);

  logic [NW-1:0] s_bus;
  logic s_clk, s_display_on, s_hs_n, s_vs_n, s_de;
  logic [CW-1:0] s_r, s_g, s_b;
  logic clk_d_ff;
  logic rise;
  logic hs_d_ff, vs_d_ff, de_d_ff;
  logic hs_fall, hs_rise, vs_fall, vs_rise;
  logic [9:0] hsync_ff, hbp_ff, hfp_ff, hact_ff;
  logic [9:0] vact_ff, vsync_ff, vbp_ff, vfp_ff;
  logic [9:0] vact_end, vfp_end;
  logic in_hbp_ff, in_hfp_ff, seen_de_ff, vframe_ff;
  rgbp_pkg::rgbp_vstate_t vst_ff;

  // every pin, pixel clock included, crosses into clock_i here
  rgbp_sync2 #(.W(NW)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i({pixel_clock_i, display_on_i, hsync_n_i, vsync_n_i,
          pixel_valid_i, red_bits_i, green_bits_i, blue_bits_i}),
    .q_o(s_bus)
  );
  // data and clock pass the same two flops, so skew is kept
  assign {s_clk, s_display_on, s_hs_n, s_vs_n, s_de, s_r, s_g, s_b} = s_bus;

  // pixel clock rising edge detect on synced copy
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clk_d_ff <= 1'b0;
    end else begin
      clk_d_ff <= s_clk;
    end
  end
  assign rise = s_clk & ~clk_d_ff;

  // previous sampled control levels, updated only at pixel edges
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hs_d_ff <= 1'b1;
      vs_d_ff <= 1'b1;
      de_d_ff <= 1'b0;
    end else if (rise) begin
      hs_d_ff <= s_hs_n;
      vs_d_ff <= s_vs_n;
      de_d_ff <= s_de;
    end
  end
  // syncs are active low
  assign hs_fall = rise & hs_d_ff & ~s_hs_n;
  assign hs_rise = rise & ~hs_d_ff & s_hs_n;
  assign vs_fall = rise & vs_d_ff & ~s_vs_n;
  assign vs_rise = rise & ~vs_d_ff & s_vs_n;

  // standby mirrors display_on; capture stops in standby
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      standby_o <= 1'b1;
    end else begin
      standby_o <= ~s_display_on;
    end
  end

  // pixel capture: one pixel per pixel clock while valid, for the first HA pixels of a line only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pix_stb_o <= 1'b0;
      pix_red_o <= '0;
      pix_green_o <= '0;
      pix_blue_o <= '0;
      pix_x_o <= '0;
      pix_y_o <= '0;
    end else begin
      pix_stb_o <= 1'b0;
      if (rise && s_de && s_display_on && hact_ff < HA) begin
        pix_stb_o <= 1'b1;
        pix_red_o <= s_r; // bit 0 is lsb
        pix_green_o <= s_g;
        pix_blue_o <= s_b;
        pix_x_o <= hact_ff;
        pix_y_o <= vact_ff;
      end
    end
  end

  // horizontal phase counters, measured in pixel clocks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hsync_ff <= '0;
      hbp_ff <= '0;
      hfp_ff <= '0;
      hact_ff <= '0;
      in_hbp_ff <= 1'b0;
      in_hfp_ff <= 1'b0;
    end else if (rise) begin
      if (hs_fall) begin
        hsync_ff <= 10'h001;
        hact_ff <= '0;
        in_hfp_ff <= 1'b0;
      end else begin
        if (!s_hs_n && hsync_ff != 10'h3ff) hsync_ff <= hsync_ff + 10'h001;
      end
      // back porch runs from sync end to first valid
      if (hs_rise) begin
        in_hbp_ff <= 1'b1;
        hbp_ff <= 10'h001;
      end else if (in_hbp_ff && !s_de && hbp_ff != 10'h3ff) begin
        hbp_ff <= hbp_ff + 10'h001;
      end
      if (s_de) begin
        in_hbp_ff <= 1'b0;
        hact_ff <= hact_ff + 10'h001;
      end
      if (de_d_ff && !s_de) begin
        in_hfp_ff <= 1'b1;
        hfp_ff <= 10'h001;
      end else if (in_hfp_ff && s_hs_n && hfp_ff != 10'h3ff) begin
        hfp_ff <= hfp_ff + 10'h001;
      end
    end
  end

  // line check at each hsync start that ends a line with valid pixels, outside standby; flag is sticky until reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      htiming_err_o <= 1'b0;
    end else if (hs_fall && s_display_on && hact_ff != 10'h000) begin
      if (hact_ff != HA) htiming_err_o <= 1'b1;
      if (hsync_ff < 10'(`RGBP_HSYNC_MIN) ||
          hsync_ff > 10'(`RGBP_HSYNC_MAX)) htiming_err_o <= 1'b1;
      if (hbp_ff < 10'(`RGBP_HBP_MIN) ||
          hbp_ff > 10'(`RGBP_HBP_MAX)) htiming_err_o <= 1'b1;
      if (hfp_ff < 10'(`RGBP_HFP_MIN) ||
          hfp_ff > 10'(`RGBP_HFP_MAX)) htiming_err_o <= 1'b1;
      if (hbp_ff + hact_ff + hfp_ff < 10'(`RGBP_HTOT_MIN) ||
          hbp_ff + hact_ff + hfp_ff > 10'(`RGBP_HTOT_MAX))
        htiming_err_o <= 1'b1;
    end
  end

  // vertical tracking in lines; a line ends at hsync start
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      vst_ff <= rgbp_pkg::RGBP_V_FRONT;
      vact_ff <= '0;
      vsync_ff <= '0;
      vbp_ff <= '0;
      vfp_ff <= '0;
      seen_de_ff <= 1'b0;
      vframe_ff <= 1'b0;
    end else if (rise) begin
      if (s_de) seen_de_ff <= 1'b1;
      // the line that ends on this edge is added in vact_end / vfp_end
      if (vs_fall) begin
        vst_ff <= rgbp_pkg::RGBP_V_SYNC;
        vsync_ff <= '0;
        vbp_ff <= '0;
        vact_ff <= '0;
        vfp_ff <= '0;
        seen_de_ff <= 1'b0;
        vframe_ff <= 1'b1; // next frame starts at an observed sync
      end else if (hs_fall) begin
        seen_de_ff <= 1'b0;
        case (vst_ff)
          rgbp_pkg::RGBP_V_SYNC: begin
            vsync_ff <= vsync_ff + 10'h001;
            if (vs_rise || s_vs_n) begin
              vst_ff <= rgbp_pkg::RGBP_V_BACK;
              vbp_ff <= '0;
            end
          end
          rgbp_pkg::RGBP_V_BACK: begin
            vbp_ff <= vbp_ff + 10'h001;
          end
          rgbp_pkg::RGBP_V_ACTIVE: begin
            if (seen_de_ff) begin
              vact_ff <= vact_ff + 10'h001;
            end else begin
              vst_ff <= rgbp_pkg::RGBP_V_FRONT;
              vfp_ff <= 10'h001;
            end
          end
          rgbp_pkg::RGBP_V_FRONT: begin
            if (vfp_ff != 10'h3ff) vfp_ff <= vfp_ff + 10'h001;
          end
          default: vst_ff <= rgbp_pkg::RGBP_V_FRONT;
        endcase
      end else if (s_de && vst_ff == rgbp_pkg::RGBP_V_BACK) begin
        vst_ff <= rgbp_pkg::RGBP_V_ACTIVE; // first valid opens active
      end
    end
  end

  // frame start pulse on first valid pixel of a frame
  assign frame_start_o = pix_stb_o && pix_x_o == 10'h000 &&
                         pix_y_o == 10'h000;

  // totals with the line closed by this edge, which vsync start would
  // otherwise swallow when both syncs fall on one pixel clock
  always_comb begin
    vact_end = vact_ff;
    vfp_end = vfp_ff;
    if (hs_fall && vst_ff == rgbp_pkg::RGBP_V_ACTIVE) begin
      if (seen_de_ff) vact_end = vact_ff + 10'h001;
      else vfp_end = 10'h001;
    end else if (hs_fall && vst_ff == rgbp_pkg::RGBP_V_FRONT &&
                 vfp_ff != 10'h3ff) begin
      vfp_end = vfp_ff + 10'h001;
    end
  end

  // frame check at vsync start; counts include both porches
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      vtiming_err_o <= 1'b0;
    end else if (vs_fall && s_display_on && vframe_ff) begin
      if (vact_end != VA) vtiming_err_o <= 1'b1;
      if (vsync_ff < 10'(`RGBP_VSYNC_MIN) ||
          vsync_ff > 10'(`RGBP_VSYNC_MAX)) vtiming_err_o <= 1'b1;
      if (vbp_ff < 10'(`RGBP_VBP_MIN) ||
          vbp_ff > 10'(`RGBP_VBP_MAX)) vtiming_err_o <= 1'b1;
      if (vfp_end < 10'(`RGBP_VFP_MIN) ||
          vfp_end > 10'(`RGBP_VFP_MAX)) vtiming_err_o <= 1'b1;
      if (vbp_ff + vact_end + vfp_end < 10'(`RGBP_VTOT_MIN) ||
          vbp_ff + vact_end + vfp_end > 10'(`RGBP_VTOT_MAX))
        vtiming_err_o <= 1'b1;
    end
  end
endmodule

// file: src/rgbp_params.svh
// timing and geometry constants of the parallel rgb panel receiver
// Behaviour
// - capture colour, syncs, valid on pixel_clock rise
// - display_on low is standby, high normal
// - eight bits per colour, bit 0 lsb
// - exactly 272 active lines per frame
`ifndef RGBP_PARAMS_SVH
`define RGBP_PARAMS_SVH
`define RGBP_COLOR_W 8
`define RGBP_H_ACTIVE 480
`define RGBP_V_ACTIVE 272
`define RGBP_HSYNC_MIN 2
`define RGBP_HSYNC_MAX 43
`define RGBP_HBP_MIN 3
`define RGBP_HBP_MAX 43
`define RGBP_HFP_MIN 2
`define RGBP_HFP_MAX 75
`define RGBP_HTOT_MIN 485
`define RGBP_HTOT_MAX 598
`define RGBP_VSYNC_MIN 2
`define RGBP_VSYNC_MAX 12
`define RGBP_VBP_MIN 2
`define RGBP_VBP_MAX 12
`define RGBP_VFP_MIN 2
`define RGBP_VFP_MAX 37
`define RGBP_VTOT_MIN 276
`define RGBP_VTOT_MAX 321
`define RGBP_CNT_W 10
`endif

// file: src/rgbp_pkg.sv
// types shared by the panel receiver
package rgbp_pkg;
  typedef enum logic [1:0] {
    RGBP_V_SYNC,
    RGBP_V_BACK,
    RGBP_V_ACTIVE,
    RGBP_V_FRONT
  } rgbp_vstate_t;
endpackage

// file: src/rgbp_sync2.sv
// two-flop synchroniser for a bus of pin inputs
module rgbp_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // pins and synced copy
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;
endmodule

// file: testbench/rgbp_panel_rx_properties.sv
// port checker for the parallel rgb panel receiver
`include "rgbp_params.svh"
module rgbp_panel_rx_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // panel pins
  input wire logic pixel_clock_i,
  input wire logic display_on_i,
  input wire logic hsync_n_i,
  input wire logic vsync_n_i,
  input wire logic pixel_valid_i,
  input wire logic [`RGBP_COLOR_W-1:0] red_bits_i,
  input wire logic [`RGBP_COLOR_W-1:0] green_bits_i,
  input wire logic [`RGBP_COLOR_W-1:0] blue_bits_i,
  // outputs
  input wire logic pix_stb_o,
  input wire logic [`RGBP_COLOR_W-1:0] pix_red_o,
  input wire logic [`RGBP_COLOR_W-1:0] pix_green_o,
  input wire logic [`RGBP_COLOR_W-1:0] pix_blue_o,
  input wire logic [`RGBP_CNT_W-1:0] pix_x_o,
  input wire logic [`RGBP_CNT_W-1:0] pix_y_o,
  input wire logic frame_start_o,
  input wire logic standby_o,
  input wire logic htiming_err_o,
  input wire logic vtiming_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_stb_pulse: assert property (pix_stb_o |=> !pix_stb_o)
    else $error("pixel strobe longer than one cycle");
  a_stb_rise: assert property (pix_stb_o |->
    $past(pixel_clock_i, 2) && !$past(pixel_clock_i, 6))
    else $error("pixel strobe without pixel clock rise");
  a_stb_gated: assert property (pix_stb_o |->
    $past(pixel_valid_i, 3) && $past(display_on_i, 3))
    else $error("pixel strobe while invalid or standby");
  a_colour_capture: assert property (pix_stb_o |->
    pix_red_o == $past(red_bits_i, 3) && pix_blue_o == $past(blue_bits_i, 3)
    && pix_green_o == $past(green_bits_i, 3))
    else $error("captured colour differs from pins");
  a_standby_on: assert property (
    (!display_on_i)[*5] |=> standby_o)
    else $error("standby not entered");
  a_standby_off: assert property (display_on_i[*5] |=> !standby_o)
    else $error("standby not left");
  a_x_bound: assert property (
    pix_stb_o |-> pix_x_o < `RGBP_H_ACTIVE)
    else $error("pixel index past line end");
  a_y_bound: assert property (
    pix_stb_o |-> pix_y_o < `RGBP_V_ACTIVE)
    else $error("line index past frame end");
  a_frame_mark: assert property (frame_start_o ==
    (pix_stb_o && pix_x_o == 0 && pix_y_o == 0))
    else $error("frame start mark wrong");
  a_herr_sticky: assert property (htiming_err_o |=> htiming_err_o)
    else $error("line timing flag dropped");
  a_herr_at_sync: assert property ($rose(htiming_err_o) |->
    !$past(hsync_n_i, 1) && !$past(hsync_n_i, 2))
    else $error("line timing flag away from line sync");
  a_verr_sticky: assert property (vtiming_err_o |=> vtiming_err_o)
    else $error("frame timing flag dropped");
  a_verr_at_sync: assert property ($rose(vtiming_err_o) |->
    !$past(vsync_n_i, 1) && !$past(vsync_n_i, 2))
    else $error("frame timing flag away from frame sync");
endmodule
bind rgbp_panel_rx rgbp_panel_rx_properties u_chk (.*);

// file: testbench/rgbp_host_model.sv
// host controller model driving the parallel rgb pins
module rgbp_host_model (
  // system clock paces the pixel clock
  input wire logic clock_i,
  // panel pins, always actively driven
  output logic pixel_clock_o,
  output logic hsync_n_o,
  output logic vsync_n_o,
  output logic pixel_valid_o,
  output logic [7:0] red_o,
  output logic [7:0] green_o,
  output logic [7:0] blue_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] k;
  // supply and backlight stay on for the whole run, so the power
  // intervals and the backlight order are never exercised here
  // all pins low until the first line, as while the supply is off
  initial begin
    pixel_clock_o = 1'b0;
    {hsync_n_o, vsync_n_o, pixel_valid_o} = 3'b000;
    {red_o, green_o, blue_o} = '0;
    k = '0;
  end
  // pins change on the pixel clock fall, 32 ns before the rise
  task automatic px(input logic hs_n, input logic de);
    @(negedge clock_i);
    pixel_clock_o = 1'b0;
    hsync_n_o = hs_n;
    pixel_valid_o = de;
    // blanking data keeps toggling so stale values never match
    red_o = de ? k[7:0] : ~red_o;
    green_o = de ? k[8:1] : ~green_o;
    blue_o = de ? ~k[7:0] : ~blue_o;
    k = k + 9'(de);
    repeat (4) @(negedge clock_i);
    pixel_clock_o = 1'b1; // ten system clocks a pixel
    repeat (5) @(negedge clock_i);
  endtask
  // one line: sync, back porch 3, pixels, front porch 2
  task automatic line(input int hs, input int n, input logic vs_n);
    vsync_n_o = vs_n;
    k = '0;
    repeat (hs) px(1'b0, 1'b0);
    repeat (3) px(1'b1, 1'b0);
    repeat (n) px(1'b1, 1'b1);
    repeat (2) px(1'b1, 1'b0);
  endtask
endmodule

// file: testbench/rgbp_panel_rx_tb.sv
// self-checking bench for the parallel rgb panel receiver
module rgbp_panel_rx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic display_on_i = 1'b1;
  logic pclk, hs_n, vs_n, de, stb, fs, stby, herr, verr;
  logic [7:0] r, g, b, pr, pg, pb;
  logic [9:0] px_x, px_y;
  int n_fail = 0, n_tests = 0, cyc = 0, cnt = 0, ey = 0;
  always #4 clock_i = ~clock_i;
  rgbp_host_model u_host (.clock_i(clock_i), .pixel_clock_o(pclk),
    .hsync_n_o(hs_n), .vsync_n_o(vs_n), .pixel_valid_o(de), .red_o(r),
    .green_o(g), .blue_o(b));
  rgbp_panel_rx u_dut (.clock_i(clock_i), .rst_i(rst_i),
    .pixel_clock_i(pclk), .display_on_i(display_on_i), .hsync_n_i(hs_n),
    .vsync_n_i(vs_n), .pixel_valid_i(de), .red_bits_i(r),
    .green_bits_i(g), .blue_bits_i(b), .pix_stb_o(stb), .pix_red_o(pr),
    .pix_green_o(pg), .pix_blue_o(pb), .pix_x_o(px_x), .pix_y_o(px_y),
    .frame_start_o(fs), .standby_o(stby), .htiming_err_o(herr),
    .vtiming_err_o(verr));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // each strobe must carry the next pixel in order
  always @(posedge clock_i) begin
    if (stb === 1'b1) begin
      check(px_x, 16'(cnt));
      check(pr, cnt[7:0]);
      check(pg, cnt[8:1]);
      check(pb, 8'(~cnt[7:0]));
      check(px_y, 16'(ey));
      check(fs, 16'(cnt == 0 && ey == 0));
      cnt++;
    end
  end
  // a full legal frame would run too long, so the bench runs short ones
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic ln(input int hs, input int n, input logic v_n);
    cnt = 0;
    u_host.line(hs, n, v_n);
  endtask
  task automatic t_capture();
    ln(2, 0, 1'b0);
    ln(2, 0, 1'b1);
    ln(2, 480, 1'b1);
    check(cnt, 480);
    ey = 1;
    ln(2, 480, 1'b1);
    check(cnt, 480);
    check(herr, 0);
    check(verr, 0);
    $display("test capture done");
  endtask
  task automatic t_errors();
    ey = 2;
    ln(1, 480, 1'b1);
    ln(2, 0, 1'b1);
    check(herr, 1);
    ln(2, 0, 1'b0);
    check(verr, 1);
    $display("test timing flags done");
  endtask
  task automatic t_beyond();
    ln(2, 0, 1'b1);
    ey = 0;
    ln(2, 482, 1'b1);
    check(cnt, 480);
    $display("test line overrun done");
  endtask
  task automatic t_standby();
    display_on_i = 1'b0;
    repeat (6) @(negedge clock_i);
    check(stby, 1);
    ey = 1;
    ln(2, 480, 1'b1);
    check(cnt, 0);
    display_on_i = 1'b1;
    repeat (6) @(negedge clock_i);
    check(stby, 0);
    $display("test standby done");
  endtask
  // reset for 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(negedge clock_i);
    check(stby, 1);
    rst_i = 1'b0;
    repeat (6) @(negedge clock_i);
    t_capture();
    t_errors();
    t_beyond();
    t_standby();
    end_sim();
  end
endmodule
